// ===== common/txfth_pkg.sv
// constants and carrier types of the transmit fifo threshold block
// assumes a single core clock; all users write txfth_pkg::name
package txfth_pkg;

  // ----------------------------------------------------------------
  // fifo geometry
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH      = 64;
  localparam int unsigned PTR_W      = 6;
  localparam int unsigned CNT_W      = 7;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned SKID_DEPTH = 2;

  localparam logic [CNT_W-1:0] CNT_DEPTH = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 7'h00;

  // ----------------------------------------------------------------
  // trigger select, counted in empty locations
  // ----------------------------------------------------------------
  localparam int unsigned TRIG_SEL_LSB = 4;
  localparam int unsigned TRIG_SEL_MSB = 5;
  localparam logic [CNT_W-1:0] TRIG_LVL_0 = 7'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL_1 = 7'h10;
  localparam logic [CNT_W-1:0] TRIG_LVL_2 = 7'h20;
  localparam logic [CNT_W-1:0] TRIG_LVL_3 = 7'h38;

  // ----------------------------------------------------------------
  // interrupt identification and hysteresis
  // ----------------------------------------------------------------
  localparam int unsigned      ID_W        = 5;
  localparam logic [ID_W-1:0]  ID_NONE     = 5'h01;
  localparam logic [ID_W-1:0]  ID_THR_EMPTY = 5'h02;
  localparam logic [1:0]       HYST_WRITES = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } txfth_beat_t;

  typedef struct packed {
    logic       thresh_en;
    logic [1:0] trig_sel;
  } txfth_ctrl_t;

endpackage : txfth_pkg

// ===== core/txfth_core.sv
// transmit and receive fifos with transmit threshold interrupt and dma request
// assumes host, dma and transmitter logic run on CLK; no synchronisers needed
`timescale 1ns/1ps
`default_nettype none

// Contract
// - sixty-four byte transmit and receive fifos
// - two-bit field picks one of four levels
// - empty count reaching level raises interrupt
// - no new threshold interrupt before two writes
// - dma request when empty count exceeds level
// - dma request drops only when fifo full
// - interrupt held until write or ident read
// - ident read drops interrupt, no empty re-raise
// - write services; later drain-empty raises again
// - transmit fifo reset raises interrupt
// - five-bit interrupt source identifier reported
module txfth_core (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire txfth_pkg::txfth_ctrl_t        FIFO_CTRL,
  input  wire logic                          TX_FIFO_RESET,
  input  wire logic                          IDENT_READ,
  input  wire txfth_pkg::txfth_beat_t        HOLD_WR,
  output logic                               HOLD_WR_READY,
  output txfth_pkg::txfth_beat_t             TX_OUT,
  input  wire logic                          TX_OUT_READY,
  input  wire txfth_pkg::txfth_beat_t        RX_IN,
  output logic                               RX_IN_READY,
  output txfth_pkg::txfth_beat_t             RX_OUT,
  input  wire logic                          RX_OUT_READY,
  output logic [txfth_pkg::CNT_W-1:0]        TX_EMPTY_COUNT,
  output logic                               TX_DMA_REQUEST,
  output logic                               INTERRUPT_OUT,
  output logic [txfth_pkg::ID_W-1:0]         INT_IDENT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [txfth_pkg::CNT_W-1:0] cnt_step(
    input logic [txfth_pkg::CNT_W-1:0] cnt,
    input logic                        inc,
    input logic                        dec
  );
    logic [txfth_pkg::CNT_W-1:0] r;
    r = cnt;
    if (inc && !dec) begin
      r = cnt + 7'h01;
    end else if (dec && !inc) begin
      r = cnt - 7'h01;
    end
    return r;
  endfunction : cnt_step

  function automatic logic [txfth_pkg::CNT_W-1:0] trig_level(
    input txfth_pkg::txfth_ctrl_t ctrl
  );
    logic [txfth_pkg::CNT_W-1:0] r;
    r = txfth_pkg::CNT_DEPTH;
    if (ctrl.thresh_en) begin
      case (ctrl.trig_sel)
        2'h0: r = txfth_pkg::TRIG_LVL_0;
        2'h1: r = txfth_pkg::TRIG_LVL_1;
        2'h2: r = txfth_pkg::TRIG_LVL_2;
        default: r = txfth_pkg::TRIG_LVL_3;
      endcase
    end
    return r;
  endfunction : trig_level

  // ----------------------------------------------------------------
  // transmit fifo storage
  // ----------------------------------------------------------------
  logic [txfth_pkg::DATA_W-1:0] tx_mem [txfth_pkg::DEPTH];
  logic [txfth_pkg::PTR_W-1:0]  tx_wp_reg;
  logic [txfth_pkg::PTR_W-1:0]  tx_rp_reg;
  logic [txfth_pkg::CNT_W-1:0]  tx_cnt_reg;
  logic [txfth_pkg::CNT_W-1:0]  tx_cnt_next;
  logic                         tx_push;
  logic                         tx_pop;
  logic                         skid_take;

  assign tx_push     = HOLD_WR.valid && HOLD_WR_READY;
  assign tx_pop      = (tx_cnt_reg != txfth_pkg::CNT_ZERO) && skid_take;
  assign tx_cnt_next = cnt_step(tx_cnt_reg, tx_push, tx_pop);

  always_ff @(posedge CLK) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= HOLD_WR.data;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || TX_FIFO_RESET) begin
      tx_wp_reg  <= 6'h00;
      tx_rp_reg  <= 6'h00;
      tx_cnt_reg <= txfth_pkg::CNT_ZERO;
    end else begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 6'h01;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 6'h01;
      end
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  // ready only while a location is free, counting this cycle's pop
  always_ff @(posedge CLK) begin
    if (RST || TX_FIFO_RESET) begin
      HOLD_WR_READY <= 1'b1;
    end else begin
      HOLD_WR_READY <= (tx_cnt_next != txfth_pkg::CNT_DEPTH);
    end
  end

  // empty locations, refreshed on every write and every drain
  always_ff @(posedge CLK) begin
    if (RST || TX_FIFO_RESET) begin
      TX_EMPTY_COUNT <= txfth_pkg::CNT_DEPTH;
    end else begin
      TX_EMPTY_COUNT <= txfth_pkg::CNT_DEPTH - tx_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // two-entry buffer toward the transmitter
  // ----------------------------------------------------------------
  logic [txfth_pkg::DATA_W-1:0] skid_data_reg [txfth_pkg::SKID_DEPTH];
  logic [1:0]                   skid_cnt_reg;
  logic                         skid_wp_reg;
  logic                         skid_rp_reg;
  logic                         skid_out;

  assign skid_take = (skid_cnt_reg != 2'h2);
  assign skid_out  = TX_OUT.valid && TX_OUT_READY;

  always_ff @(posedge CLK) begin
    if (tx_pop) begin
      skid_data_reg[skid_wp_reg] <= tx_mem[tx_rp_reg];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || TX_FIFO_RESET) begin
      skid_cnt_reg <= 2'h0;
      skid_wp_reg  <= 1'b0;
      skid_rp_reg  <= 1'b0;
    end else begin
      if (tx_pop) begin
        skid_wp_reg <= ~skid_wp_reg;
      end
      if (skid_out) begin
        skid_rp_reg <= ~skid_rp_reg;
      end
      if (tx_pop && !skid_out) begin
        skid_cnt_reg <= skid_cnt_reg + 2'h1;
      end else if (skid_out && !tx_pop) begin
        skid_cnt_reg <= skid_cnt_reg - 2'h1;
      end
    end
  end

  // output word held in its own flop so the port stays registered
  always_ff @(posedge CLK) begin
    if (RST || TX_FIFO_RESET) begin
      TX_OUT <= '0;
    end else if (!TX_OUT.valid || TX_OUT_READY) begin
      if (skid_cnt_reg != 2'h0 && !(skid_out && skid_cnt_reg == 2'h1)) begin
        TX_OUT.valid <= 1'b1;
        TX_OUT.data  <= skid_out ? skid_data_reg[~skid_rp_reg] : skid_data_reg[skid_rp_reg];
      end else begin
        TX_OUT.valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // threshold events
  // ----------------------------------------------------------------
  logic [txfth_pkg::CNT_W-1:0] level;
  logic                        at_level;
  logic                        at_level_reg;
  logic                        empty_now;
  logic                        empty_reg;
  logic                        reach_evt;
  logic                        empty_evt;

  assign level     = trig_level(FIFO_CTRL);
  assign at_level  = TX_EMPTY_COUNT >= level;
  assign empty_now = TX_EMPTY_COUNT == txfth_pkg::CNT_DEPTH;
  assign reach_evt = at_level && !at_level_reg;
  assign empty_evt = empty_now && !empty_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      at_level_reg <= 1'b1;
      empty_reg    <= 1'b1;
    end else begin
      at_level_reg <= at_level;
      empty_reg    <= empty_now;
    end
  end

  // ----------------------------------------------------------------
  // interrupt state
  // ----------------------------------------------------------------
  logic [1:0] wr_since_reg;
  logic       armed;
  logic       rearm_reg;
  logic       int_set;
  logic       int_clr;
  logic       pend_reg;

  assign armed   = (wr_since_reg == txfth_pkg::HYST_WRITES);
  assign int_set = TX_FIFO_RESET
                || (reach_evt && armed)
                || (empty_evt && rearm_reg);
  assign int_clr = tx_push || IDENT_READ;

  // writes counted since the last raise; saturates at the hysteresis
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_since_reg <= txfth_pkg::HYST_WRITES;
    end else if (int_set) begin
      wr_since_reg <= 2'h0;
    end else if (tx_push && !armed) begin
      wr_since_reg <= wr_since_reg + 2'h1;
    end
  end

  // a write completes the service and arms the drain-empty raise
  always_ff @(posedge CLK) begin
    if (RST) begin
      rearm_reg <= 1'b0;
    end else if (int_set) begin
      rearm_reg <= 1'b0;
    end else if (tx_push) begin
      rearm_reg <= 1'b1;
    end
  end

  // set wins over clear in the same cycle; an ident read alone
  // leaves rearm low so a later drain stays quiet
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= int_set || (pend_reg && !int_clr);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      INTERRUPT_OUT <= 1'b0;
      INT_IDENT     <= txfth_pkg::ID_NONE;
    end else begin
      INTERRUPT_OUT <= int_set || (pend_reg && !int_clr);
      INT_IDENT     <= (int_set || (pend_reg && !int_clr))
                       ? txfth_pkg::ID_THR_EMPTY : txfth_pkg::ID_NONE;
    end
  end

  // ----------------------------------------------------------------
  // dma request, independent of the hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      TX_DMA_REQUEST <= 1'b0;
    end else if (tx_cnt_next == txfth_pkg::CNT_DEPTH) begin
      TX_DMA_REQUEST <= 1'b0;
    end else if ((txfth_pkg::CNT_DEPTH - tx_cnt_next) > level) begin
      TX_DMA_REQUEST <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  logic [txfth_pkg::DATA_W-1:0] rx_mem [txfth_pkg::DEPTH];
  logic [txfth_pkg::PTR_W-1:0]  rx_wp_reg;
  logic [txfth_pkg::PTR_W-1:0]  rx_rp_reg;
  logic [txfth_pkg::CNT_W-1:0]  rx_cnt_reg;
  logic [txfth_pkg::CNT_W-1:0]  rx_cnt_next;
  logic                         rx_push;
  logic                         rx_pop;

  assign rx_push     = RX_IN.valid && RX_IN_READY;
  assign rx_pop      = (rx_cnt_reg != txfth_pkg::CNT_ZERO)
                    && (!RX_OUT.valid || RX_OUT_READY);
  assign rx_cnt_next = cnt_step(rx_cnt_reg, rx_push, rx_pop);

  always_ff @(posedge CLK) begin
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= RX_IN.data;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_wp_reg   <= 6'h00;
      rx_rp_reg   <= 6'h00;
      rx_cnt_reg  <= txfth_pkg::CNT_ZERO;
      RX_IN_READY <= 1'b1;
    end else begin
      if (rx_push) begin
        rx_wp_reg <= rx_wp_reg + 6'h01;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 6'h01;
      end
      rx_cnt_reg  <= rx_cnt_next;
      RX_IN_READY <= (rx_cnt_next != txfth_pkg::CNT_DEPTH);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RX_OUT <= '0;
    end else if (rx_pop) begin
      RX_OUT.valid <= 1'b1;
      RX_OUT.data  <= rx_mem[rx_rp_reg];
    end else if (RX_OUT_READY) begin
      RX_OUT.valid <= 1'b0;
    end
  end

endmodule : txfth_core

`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the tx threshold block
// assumes core, checker and dma model compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // stimulus, model and checks
  // ----------------------------------------
  logic                   clk, rst, fifo_reset, ident_read, tx_ready, dma_en;
  logic                   wr_ready, dma_req, int_out;
  logic [6:0]             empty;
  logic [4:0]             ident;
  logic [15:0]            lf;
  logic [7:0]             q[$];
  logic [7:0]             rq[$];
  logic                   rx_in_ready, rx_out_ready;
  txfth_pkg::txfth_beat_t rx_in, rx_out;
  logic [6:0]             lv[4];
  int                     bad_count, check_count, cyc;
  txfth_pkg::txfth_ctrl_t ctrl;
  txfth_pkg::txfth_beat_t host_beat, dma_beat, wr_beat, tx_out;

  assign wr_beat = dma_en ? dma_beat : host_beat;
  txfth_core DUT (.CLK(clk), .RST(rst), .FIFO_CTRL(ctrl), .TX_FIFO_RESET(fifo_reset), .IDENT_READ(ident_read),
    .HOLD_WR(wr_beat), .HOLD_WR_READY(wr_ready), .TX_OUT(tx_out), .TX_OUT_READY(tx_ready), .RX_IN(rx_in),
    .RX_IN_READY(rx_in_ready), .RX_OUT(rx_out), .RX_OUT_READY(rx_out_ready), .TX_EMPTY_COUNT(empty),
    .TX_DMA_REQUEST(dma_req), .INTERRUPT_OUT(int_out), .INT_IDENT(ident));
  txfth_dma_model u_dma (.clk(clk), .enable(dma_en), .request(dma_req), .ready(wr_ready && dma_en),
    .beat(dma_beat));

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic pulse(input logic which);
    if (which) fifo_reset = 1'b1;
    else ident_read = 1'b1;
    @(negedge clk);
    fifo_reset = 1'b0;
    ident_read = 1'b0;
    @(negedge clk);
  endtask : pulse

  task automatic wr;
    lf = nx(lf);
    host_beat = {1'b1, lf[7:0]};
    while (wr_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    host_beat = {1'b0, ~lf[7:0]};
  endtask : wr

  // random transmitter stalls until interrupt or the given count
  task automatic drain(input logic [6:0] stop);
    for (int i = 0; i < 3000 && int_out !== 1'b1 && empty !== stop; i++) begin
      lf = nx(lf);
      tx_ready = lf[0];
      @(negedge clk);
    end
    tx_ready = 1'b0;
  endtask : drain

  // receive fifo: fill until refused, then drain with random stalls
  task automatic rx_run;
    for (int i = 0; i < 200 && rx_in_ready !== 1'b0; i++) begin
      lf = nx(lf);
      rx_in = {1'b1, lf[7:0]};
      @(negedge clk);
    end
    rx_in = '0;
    // the output register holds one word beyond the fifo
    chk(8'(rq.size()), 8'(txfth_pkg::DEPTH + 1));
    for (int i = 0; i < 600 && rq.size() != 0; i++) begin
      lf = nx(lf);
      rx_out_ready = lf[0];
      @(negedge clk);
    end
    rx_out_ready = 1'b0;
    chk(8'(rq.size()), 8'h00);
  endtask : rx_run

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
    if (fifo_reset) q.delete();
    else begin
      if (tx_out.valid && tx_ready) chk(tx_out.data, q.size() != 0 ? q.pop_front() : 8'hxx);
      if (wr_beat.valid && wr_ready) q.push_back(wr_beat.data);
    end
    if (rx_out.valid && rx_out_ready) chk(rx_out.data, rq.size() != 0 ? rq.pop_front() : 8'hxx);
    if (rx_in.valid && rx_in_ready) rq.push_back(rx_in.data);
  end

  initial begin
    lv = '{txfth_pkg::TRIG_LVL_0, txfth_pkg::TRIG_LVL_1, txfth_pkg::TRIG_LVL_2, txfth_pkg::TRIG_LVL_3};
    {rst, fifo_reset, ident_read, tx_ready, dma_en} = 5'h10;
    ctrl = '0;
    host_beat = '0;
    rx_in = '0;
    rx_out_ready = 1'b0;
    lf = 16'h1655;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk({1'b0, empty}, 8'h40);
    chk({3'h0, ident}, {3'h0, txfth_pkg::ID_NONE});
    rx_run();
    for (int s = 0; s < 4; s++) begin
      ctrl = {1'b1, 2'(s)};
      pulse(1'b1);
      chk({7'h0, int_out}, 8'h01);
      chk({3'h0, ident}, {3'h0, txfth_pkg::ID_THR_EMPTY});
      pulse(1'b0);
      chk({7'h0, int_out}, 8'h00);
      dma_en = 1'b1;
      for (int i = 0; i < 300 && wr_ready !== 1'b0; i++) @(negedge clk);
      dma_en = 1'b0;
      chk({dma_req, empty}, 8'h00);
      drain(7'h7f);
      chk({7'h0, empty >= lv[s] && empty <= lv[s] + 7'h01}, 8'h01);
      if (s[0]) wr();
      else pulse(1'b0);
      @(negedge clk);
      chk({7'h0, int_out}, 8'h00);
      drain(7'h40);
      repeat (3) @(negedge clk);
      chk({int_out, empty}, {s[0], 7'h40});
    end
    // threshold off: plain empty interrupt after a write
    ctrl = '0;
    pulse(1'b1);
    wr();
    @(negedge clk);
    wr();
    repeat (3) @(negedge clk);
    chk({int_out, empty}, {1'b1, txfth_pkg::CNT_DEPTH});
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// ===== verification/txfth_dma_model.sv
// dma controller model refilling the tx fifo
// assumes beats are taken at a rising edge with valid and ready
`timescale 1ns/1ps
`default_nettype none
module txfth_dma_model (
  input  wire logic                  clk,
  input  wire logic                  enable,
  input  wire logic                  request,
  input  wire logic                  ready,
  output var txfth_pkg::txfth_beat_t beat
);
  // ----------------------------------------
  // beat source
  // ----------------------------------------
  logic       taken;
  logic [7:0] offer;
  initial begin
    beat = '0;
    taken = 1'b0;
    offer = 8'h00;
  end
  always @(posedge clk) taken <= beat.valid && ready;
  // a beat stands until taken; idle data keeps toggling
  always @(negedge clk) begin
    if (!beat.valid || taken) begin
      beat.valid <= enable && request;
      beat.data  <= (enable && request) ? offer : ~beat.data;
      offer      <= offer + 8'h01;
    end
  end
endmodule : txfth_dma_model
`default_nettype wire

// ===== verification/txfth_properties.sv
// port assertions for the tx threshold block
// assumes bind onto txfth_core, one clock CLK
`timescale 1ns/1ps
`default_nettype none
module txfth_properties (
  input wire logic                   CLK,
  input wire logic                   RST,
  input wire txfth_pkg::txfth_ctrl_t FIFO_CTRL,
  input wire logic                   TX_FIFO_RESET,
  input wire logic                   IDENT_READ,
  input wire txfth_pkg::txfth_beat_t HOLD_WR,
  input wire logic                   HOLD_WR_READY,
  input wire logic [6:0]             TX_EMPTY_COUNT,
  input wire logic                   TX_DMA_REQUEST,
  input wire logic                   INTERRUPT_OUT,
  input wire logic [4:0]             INT_IDENT
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic [6:0] lvl;
  logic       took;
  assign took = HOLD_WR.valid && HOLD_WR_READY;
  always_comb begin
    case (FIFO_CTRL.trig_sel)
      2'h0: lvl = txfth_pkg::TRIG_LVL_0;
      2'h1: lvl = txfth_pkg::TRIG_LVL_1;
      2'h2: lvl = txfth_pkg::TRIG_LVL_2;
      default: lvl = txfth_pkg::TRIG_LVL_3;
    endcase
  end
  chk_ident_code: assert property (INT_IDENT == (INTERRUPT_OUT ? txfth_pkg::ID_THR_EMPTY : txfth_pkg::ID_NONE))
    else $error("ident code mismatch");
  chk_fifo_reset: assert property (TX_FIFO_RESET |=> INTERRUPT_OUT)
    else $error("fifo reset gave no interrupt");
  chk_full_no_dma: assert property (TX_EMPTY_COUNT == 7'h00 |-> !TX_DMA_REQUEST && !HOLD_WR_READY)
    else $error("full fifo still requests");
  chk_dma_holds: assert property (TX_DMA_REQUEST ##1 TX_EMPTY_COUNT != 7'h00 |-> TX_DMA_REQUEST)
    else $error("dma request dropped early");
  chk_dma_above: assert property (!$past(RST) && $stable(FIFO_CTRL) && FIFO_CTRL.thresh_en
    && TX_EMPTY_COUNT > lvl |-> TX_DMA_REQUEST)
    else $error("dma request missing");
  chk_int_holds: assert property (INTERRUPT_OUT && !IDENT_READ && !took |=> INTERRUPT_OUT)
    else $error("interrupt dropped unserviced");
  chk_read_drops: assert property (IDENT_READ && !TX_FIFO_RESET && !$past(TX_FIFO_RESET)
    && $stable(TX_EMPTY_COUNT) ##1 $stable(TX_EMPTY_COUNT) |-> !INTERRUPT_OUT)
    else $error("ident read kept interrupt");
  chk_count_step: assert property (!$past(TX_FIFO_RESET)
    |-> 7'(TX_EMPTY_COUNT - $past(TX_EMPTY_COUNT) + 7'h01) <= 7'h02 && TX_EMPTY_COUNT <= 7'h40)
    else $error("empty count jumped");
  cov_int: cover property ($rose(INTERRUPT_OUT));
  cov_full: cover property (!HOLD_WR_READY);
  cov_dma_drop: cover property ($fell(TX_DMA_REQUEST));
endmodule : txfth_properties
bind txfth_core txfth_properties u_props (.CLK, .RST, .FIFO_CTRL, .TX_FIFO_RESET, .IDENT_READ, .HOLD_WR,
  .HOLD_WR_READY, .TX_EMPTY_COUNT, .TX_DMA_REQUEST, .INTERRUPT_OUT, .INT_IDENT);
`default_nettype wire
